// ---- rtl/i2cmt_ctrl.sv ----
// Operation
// - Holding byte moves into shift register when it is empty in master transmit mode, then shifts out.
// - Holding register accepts a new byte while the shift register is busy.
// - Holding register resets to all ones; all eight bits read and write.
// - Arbitration loss in master mode clears master and transmit select.
// - Master and transmit select pick slave rx, slave tx, master rx, tx.
// - SDA falling while SCL high sets bus busy.
// - SDA rising while SCL high clears bus busy.
// - Master write of busy one, disable zero issues a start.
// - Master write of busy zero, disable zero issues a stop.
// - Condition disable reads one, is not stored, one suppresses issue.
// - Moving the holding byte into the shift register sets buffer empty.
`timescale 1ns/100ps
`default_nettype none

module i2cmt_ctrl #(
    parameter int HALF_CYC = i2cmt_pkg::SCL_HALF_CYC
) (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Two-wire bus pins
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_n_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n_o,
    // Status
    output logic      [1:0]  mode_o,
    output logic             irq_o
);

    function automatic logic idx_hit(input logic [31:0] a,
                                     input logic [15:0] idx);
        idx_hit = (a == {14'h0000, idx, 2'b00});
    endfunction

    // Bus slave state
    i2cmt_pkg::i2cmt_req_s req;
    logic [31:0]           rdata;

    // Register state
    logic       master_select;
    logic       transmit_select;
    logic       bus_busy_flag;
    logic [7:0] transmit_holding;
    logic       hold_full;
    logic [7:0] stat;
    logic [7:0] mask;
    logic       start_req;
    logic       stop_req;

    // Pin synchronisers
    logic scl_meta;
    logic scl_s;
    logic scl_d;
    logic sda_meta;
    logic sda_s;
    logic sda_d;

    // Engine state
    i2cmt_pkg::i2cmt_state_e state;
    i2cmt_pkg::i2cmt_state_e next_state;
    logic [15:0]             cnt;
    logic [7:0]              bus_shift_reg;
    logic                    shift_full;
    logic [2:0]              bit_cnt;

    // Bus decode
    wire addr_phase = hsel_i & htrans_i[1] & hready_i;
    wire wr_data    = req.valid & req.write;
    wire wr_ctrl1   = wr_data & (req.idx == i2cmt_pkg::CTRL1_IDX);
    wire wr_ctrl2   = wr_data & (req.idx == i2cmt_pkg::CTRL2_IDX);
    wire wr_stat    = wr_data & (req.idx == i2cmt_pkg::STAT_IDX);
    wire wr_mask    = wr_data & (req.idx == i2cmt_pkg::MASK_IDX);
    wire wr_hold    = wr_data & (req.idx == i2cmt_pkg::HOLD_IDX);
    wire [7:0] wbyte = hwdata_i[7:0];

    // Condition disable is never stored; a written one blocks issue
    wire cond_issue_disable = wbyte[i2cmt_pkg::CTRL2_SCP_BIT];
    wire issue_ok   = wr_ctrl2 & ~cond_issue_disable & master_select;
    wire issue_strt = issue_ok
                      & wbyte[i2cmt_pkg::CTRL2_BUS_BUSY_FLAG_BIT];
    wire issue_stop = issue_ok & ~wbyte[i2cmt_pkg::CTRL2_BUS_BUSY_FLAG_BIT];

    // Read mux
    wire [7:0] ctrl1_rd = {2'b00, master_select, transmit_select, 4'h0};
    wire [7:0] ctrl2_rd = {bus_busy_flag, 1'b1, 6'h00};
    wire [7:0] rd_byte;
    assign rd_byte =
        idx_hit(haddr_i, i2cmt_pkg::CTRL1_IDX) ? ctrl1_rd :
        idx_hit(haddr_i, i2cmt_pkg::CTRL2_IDX) ? ctrl2_rd :
        idx_hit(haddr_i, i2cmt_pkg::STAT_IDX)  ? stat :
        idx_hit(haddr_i, i2cmt_pkg::MASK_IDX)  ? mask :
        idx_hit(haddr_i, i2cmt_pkg::HOLD_IDX)  ? transmit_holding :
        8'h00;

    // Bus conditions seen on the synchronised wires
    wire cond_start = scl_s & scl_d & sda_d & ~sda_s;
    wire cond_stop  = scl_s & scl_d & ~sda_d & sda_s;

    // Engine control
    wire half_done = (cnt == 16'(HALF_CYC - 1));
    wire cur_bit   = bus_shift_reg[7];
    wire in_master = master_select & transmit_select;
    wire arb_lost  = (state == i2cmt_pkg::EN_BIT_HIGH) & cur_bit & scl_s
                     & ~sda_s & master_select;
    // Load only with room in the shift register, so a byte may wait
    wire load_shift = hold_full & ~shift_full & in_master;
    wire take_start = start_req & (state == i2cmt_pkg::EN_IDLE)
                      & ~bus_busy_flag;
    wire shift_done = (state == i2cmt_pkg::EN_ACK_HIGH) & half_done;

    // Status events; set wins over a write-one clear
    wire [7:0] stat_set;
    assign stat_set[i2cmt_pkg::STAT_TX_BUFFER_EMPTY_BIT] =
        load_shift | take_start
        | (wr_ctrl1 & wbyte[i2cmt_pkg::CTRL1_TRS_BIT] & ~transmit_select);
    assign stat_set[6:3] = 4'h0;
    assign stat_set[i2cmt_pkg::STAT_ARBL_BIT] = arb_lost;
    assign stat_set[i2cmt_pkg::STAT_STRT_BIT] = cond_start;
    assign stat_set[i2cmt_pkg::STAT_STOP_BIT] = cond_stop;
    wire [7:0] stat_clr = (wr_stat ? wbyte : 8'h00)
        | (wr_hold ? (8'h01 << i2cmt_pkg::STAT_TX_BUFFER_EMPTY_BIT) : 8'h00);
    wire [7:0] next_stat = (stat & ~stat_clr) | stat_set;

    // Wire pulls from the engine state
    i2cmt_pkg::i2cmt_pull_s next_pull;
    i2cmt_pkg::i2cmt_pull_s pull;

    always_comb begin
        next_state = state;
        next_pull  = '0;
        case (state)
            i2cmt_pkg::EN_IDLE: begin
                if (take_start) begin
                    next_state = i2cmt_pkg::EN_START;
                end
            end
            i2cmt_pkg::EN_START: begin
                next_pull.sda = 1'b1;
                if (half_done) begin
                    next_state = i2cmt_pkg::EN_HOLD;
                end
            end
            i2cmt_pkg::EN_HOLD: begin
                // Master keeps SCL low between bytes
                next_pull.scl = 1'b1;
                next_pull.sda = 1'b1;
                if (shift_full & in_master) begin
                    next_state = i2cmt_pkg::EN_BIT_LOW;
                end else if (stop_req) begin
                    next_state = i2cmt_pkg::EN_STOP_LOW;
                end else if (start_req) begin
                    next_state = i2cmt_pkg::EN_RS_PREP;
                end
            end
            i2cmt_pkg::EN_RS_PREP: begin
                next_pull.scl = 1'b1;
                if (half_done) begin
                    next_state = i2cmt_pkg::EN_RS_HIGH;
                end
            end
            i2cmt_pkg::EN_RS_HIGH: begin
                if (half_done) begin
                    next_state = i2cmt_pkg::EN_START;
                end
            end
            i2cmt_pkg::EN_BIT_LOW: begin
                next_pull.scl = 1'b1;
                next_pull.sda = ~cur_bit;
                if (half_done) begin
                    next_state = i2cmt_pkg::EN_BIT_HIGH;
                end
            end
            i2cmt_pkg::EN_BIT_HIGH: begin
                next_pull.sda = ~cur_bit;
                if (arb_lost) begin
                    next_state = i2cmt_pkg::EN_IDLE;
                    next_pull  = '0;
                end else if (half_done) begin
                    next_state = (bit_cnt == 3'h0) ? i2cmt_pkg::EN_ACK_LOW
                                                   : i2cmt_pkg::EN_BIT_LOW;
                    next_pull.scl = 1'b1;
                end
            end
            i2cmt_pkg::EN_ACK_LOW: begin
                next_pull.scl = 1'b1;
                if (half_done) begin
                    next_state = i2cmt_pkg::EN_ACK_HIGH;
                end
            end
            i2cmt_pkg::EN_ACK_HIGH: begin
                // SDA waits a cycle so it never moves while SCL is high
                if (half_done) begin
                    next_state = i2cmt_pkg::EN_HOLD;
                    next_pull.scl = 1'b1;
                end
            end
            i2cmt_pkg::EN_STOP_LOW: begin
                next_pull.scl = 1'b1;
                next_pull.sda = 1'b1;
                if (half_done) begin
                    next_state = i2cmt_pkg::EN_STOP_HIGH;
                end
            end
            i2cmt_pkg::EN_STOP_HIGH: begin
                next_pull.sda = 1'b1;
                if (half_done) begin
                    next_state = i2cmt_pkg::EN_STOP_DONE;
                end
            end
            i2cmt_pkg::EN_STOP_DONE: begin
                if (half_done) begin
                    next_state = i2cmt_pkg::EN_IDLE;
                end
            end
            default: begin
                next_state = i2cmt_pkg::EN_IDLE;
            end
        endcase
    end

    // Half-period timer; bit and ack high phases count only once SCL is seen high,
    // so a slave stretching the clock is honoured
    wire cnt_run = (state != i2cmt_pkg::EN_IDLE)
                   & (state != i2cmt_pkg::EN_HOLD)
                   & ~(((state == i2cmt_pkg::EN_BIT_HIGH)
                        | (state == i2cmt_pkg::EN_ACK_HIGH)) & ~scl_s);
    wire [15:0] next_cnt = (next_state != state) ? 16'h0000 :
                           cnt_run ? cnt + 16'h0001 : cnt;

    // AHB slave: zero wait states, always OKAY
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            req   <= '0;
            rdata <= 32'h0000_0000;
        end else begin
            req.valid <= addr_phase;
            req.write <= hwrite_i;
            req.idx   <= haddr_i[17:2];
            rdata     <= {24'h000000, rd_byte};
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            {scl_meta, scl_s, scl_d} <= 3'b111;
            {sda_meta, sda_s, sda_d} <= 3'b111;
        end else begin
            {scl_meta, scl_s, scl_d} <= {scl_i, scl_meta, scl_s};
            {sda_meta, sda_s, sda_d} <= {sda_i, sda_meta, sda_s};
        end
    end

    // Mode bits
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            master_select   <= i2cmt_pkg::MODE_RST;
            transmit_select <= i2cmt_pkg::MODE_RST;
        end else if (arb_lost) begin
            master_select   <= 1'b0;
            transmit_select <= 1'b0;
        end else if (wr_ctrl1) begin
            master_select   <= wbyte[i2cmt_pkg::CTRL1_MST_BIT];
            transmit_select <= wbyte[i2cmt_pkg::CTRL1_TRS_BIT];
        end
    end

    // Bus busy follows the wire conditions only
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            bus_busy_flag <= 1'b0;
        end else if (cond_start) begin
            bus_busy_flag <= 1'b1;
        end else if (cond_stop) begin
            bus_busy_flag <= 1'b0;
        end
    end

    // Pending start and stop requests
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || arb_lost) begin
            start_req <= 1'b0;
            stop_req  <= 1'b0;
        end else begin
            start_req <= issue_strt | (start_req
                         & (state != i2cmt_pkg::EN_START));
            stop_req  <= issue_stop | (stop_req
                         & (state != i2cmt_pkg::EN_STOP_LOW));
        end
    end

    // Holding register and shift register
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            transmit_holding <= i2cmt_pkg::HOLD_RST;
            hold_full        <= 1'b0;
            bus_shift_reg    <= 8'h00;
            shift_full       <= 1'b0;
            bit_cnt          <= 3'h7;
        end else begin
            if (wr_hold) begin
                transmit_holding <= wbyte;
            end
            hold_full <= wr_hold | (hold_full & ~load_shift);
            if (load_shift) begin
                bus_shift_reg <= transmit_holding;
                bit_cnt       <= 3'h7;
                shift_full    <= 1'b1;
            end else if (arb_lost | shift_done) begin
                shift_full    <= 1'b0;
            end else if ((state == i2cmt_pkg::EN_BIT_HIGH) & half_done) begin
                bus_shift_reg <= {bus_shift_reg[6:0], 1'b0};
                bit_cnt       <= bit_cnt - 3'h1;
            end
        end
    end

    // Engine, status and mask
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state <= i2cmt_pkg::EN_IDLE;
            cnt   <= 16'h0000;
            pull  <= '0;
            stat  <= i2cmt_pkg::STAT_RST;
            mask  <= i2cmt_pkg::MASK_RST;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            pull  <= next_pull;
            stat  <= next_stat;
            if (wr_mask) begin
                mask <= wbyte;
            end
        end
    end

    assign hrdata_o    = rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign scl_o       = 1'b0;
    assign sda_o       = 1'b0;
    assign scl_oe_n_o  = ~pull.scl;
    assign sda_oe_n_o  = ~pull.sda;
    assign mode_o      = {master_select, transmit_select};
    assign irq_o       = |(stat & mask);

endmodule

`default_nettype wire

// ---- rtl/i2cmt_pkg.sv ----
package i2cmt_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] CTRL1_IDX = 16'hf078;
    localparam logic [15:0] CTRL2_IDX = 16'hf079;
    localparam logic [15:0] STAT_IDX  = 16'hf07c;
    localparam logic [15:0] MASK_IDX  = 16'hf07d;
    localparam logic [15:0] HOLD_IDX  = 16'hf07e;

    // Field positions
    localparam int CTRL1_MST_BIT  = 5;
    localparam int CTRL1_TRS_BIT  = 4;
    localparam int CTRL2_BUS_BUSY_FLAG_BIT = 7;
    localparam int CTRL2_SCP_BIT  = 6;
    localparam int STAT_TX_BUFFER_EMPTY_BIT  = 7;
    localparam int STAT_ARBL_BIT  = 2;
    localparam int STAT_STRT_BIT  = 1;
    localparam int STAT_STOP_BIT  = 0;

    // Reset values
    localparam logic [7:0] HOLD_RST  = 8'hff;
    localparam logic [7:0] STAT_RST  = 8'h00;
    localparam logic [7:0] MASK_RST  = 8'h00;
    localparam logic       MODE_RST  = 1'b0;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCL_HALF_NS   = 2500;
    localparam int SCL_HALF_CYC  = SCL_HALF_NS / CLK_PERIOD_NS;

    // Operating modes as {master_select, transmit_select}
    typedef enum logic [1:0] {
        MODE_SLV_RX = 2'b00,
        MODE_SLV_TX = 2'b01,
        MODE_MST_RX = 2'b10,
        MODE_MST_TX = 2'b11
    } i2cmt_mode_e;

    // Bit engine states
    typedef enum logic [3:0] {
        EN_IDLE      = 4'b0000,
        EN_START     = 4'b0001,
        EN_HOLD      = 4'b0010,
        EN_RS_PREP   = 4'b0011,
        EN_RS_HIGH   = 4'b0100,
        EN_BIT_LOW   = 4'b0101,
        EN_BIT_HIGH  = 4'b0110,
        EN_ACK_LOW   = 4'b0111,
        EN_ACK_HIGH  = 4'b1000,
        EN_STOP_LOW  = 4'b1001,
        EN_STOP_HIGH = 4'b1010,
        EN_STOP_DONE = 4'b1011
    } i2cmt_state_e;

    // Captured AHB address phase
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] idx;
    } i2cmt_req_s;

    // Open-drain pull requests, one means pull the wire low
    typedef struct packed {
        logic scl;
        logic sda;
    } i2cmt_pull_s;

endpackage

// ---- sim/i2cmt_ctrl_properties.sv ----
`timescale 1ns/100ps
`default_nettype none

module i2cmt_ctrl_properties #(
    parameter int HALF_CYC = 4
) (
    // Watched top-level ports
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_o,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    input  wire logic        scl_oe_n_o,
    input  wire logic        sda_oe_n_o,
    input  wire logic [1:0]  mode_o
);
    logic        dv;
    logic        dw;
    logic        scl_q;
    logic        sda_q;
    logic        busy;
    logic [15:0] di;
    logic [3:0]  age;
    wire         idle = scl_oe_n_o & sda_oe_n_o & scl_i & sda_i;
    wire         rd1  = dv & ~dw & (di == i2cmt_pkg::CTRL1_IDX);
    wire         rd2  = dv & ~dw & (di == i2cmt_pkg::CTRL2_IDX);
    wire         wr1  = dv & dw & (di == i2cmt_pkg::CTRL1_IDX);
    wire         wr2  = dv & dw & (di == i2cmt_pkg::CTRL2_IDX);
    wire         cnd  = scl_q & scl_i & (sda_q != sda_i);

    // Age lets the design's input synchroniser settle before reads count
    always_ff @(posedge clk_sys_i) begin
        dv    <= reset_n_i & hsel_i & htrans_i[1] & hready_i;
        dw    <= hwrite_i;
        di    <= haddr_i[17:2];
        scl_q <= scl_i | ~reset_n_i;
        sda_q <= sda_i | ~reset_n_i;
        busy  <= reset_n_i & (cnd ? sda_q : busy);
        age   <= (!reset_n_i || cnd) ? 4'h0 : age + {3'h0, age != 4'hf};
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    property p_busy_set;
        rd2 && busy && age >= 4'h8 |-> hrdata_o[7];
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("busy flag low after start");
    property p_busy_clr;
        rd2 && !busy && age >= 4'h8 |-> !hrdata_o[7];
    endproperty
    a_busy_clr: assert property (p_busy_clr)
        else $error("busy flag high after stop");
    property p_scp_read;
        rd2 |-> hrdata_o[6];
    endproperty
    a_scp_read: assert property (p_scp_read)
        else $error("condition disable read zero");
    property p_mode_read;
        rd1 |-> hrdata_o[5:4] == mode_o;
    endproperty
    a_mode_read: assert property (p_mode_read)
        else $error("mode output differs from select bits");
    property p_arb_clear;
        $fell(mode_o[1]) && !$past(wr1) |-> mode_o == 2'b00;
    endproperty
    a_arb_clear: assert property (p_arb_clear)
        else $error("master loss left transmit select set");
    property p_start;
        wr2 && hwdata_i[7:6] == 2'b10 && mode_o[1] && !busy && idle
            |-> ##[1:20] (!sda_oe_n_o && scl_oe_n_o);
    endproperty
    a_start: assert property (p_start)
        else $error("no start after start request");
    property p_stop;
        wr2 && hwdata_i[7:6] == 2'b00 && mode_o[1] && busy && !scl_oe_n_o
            |-> ##[1:200] ($rose(sda_oe_n_o) && scl_i);
    endproperty
    a_stop: assert property (p_stop)
        else $error("no stop after stop request");
    property p_scp_hold;
        wr2 && hwdata_i[6] && idle && !busy |-> ##1 sda_oe_n_o [*8];
    endproperty
    a_scp_hold: assert property (p_scp_hold)
        else $error("condition issued with disable set");
endmodule

bind i2cmt_ctrl i2cmt_ctrl_properties #(.HALF_CYC(HALF_CYC)) i_chk (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .scl_i(scl_i), .sda_i(sda_i), .scl_oe_n_o(scl_oe_n_o),
    .sda_oe_n_o(sda_oe_n_o), .mode_o(mode_o));

`default_nettype wire

// ---- sim/i2cmt_bus_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module i2cmt_bus_model (
    // Pulls from the design and from the bench
    input  wire logic       scl_oe_n_i,
    input  wire logic       sda_oe_n_i,
    input  wire logic       pull_scl_i,
    input  wire logic       pull_sda_i,
    // Wire levels and captured traffic
    output logic            scl_o,
    output logic            sda_o,
    output logic [8:0]      bits_o,
    output logic [7:0]      count_o,
    output logic [7:0]      starts_o
);
    // Pull-ups: a released line goes high
    assign scl_o = scl_oe_n_i & ~pull_scl_i;
    assign sda_o = sda_oe_n_i & ~pull_sda_i;

    initial begin
        bits_o   = 9'h000;
        count_o  = 8'h00;
        starts_o = 8'h00;
    end

    always @(posedge scl_o) begin
        bits_o  <= {bits_o[7:0], sda_o};
        count_o <= count_o + 8'h01;
    end

    // Start restarts the count so each frame is read from its first bit
    always @(negedge sda_o) begin
        if (scl_o) begin
            count_o  <= 8'h00;
            starts_o <= starts_o + 8'h01;
        end
    end
endmodule

`default_nettype wire

// ---- sim/i2cmt_ctrl_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module i2cmt_ctrl_tb_top;
    logic        clk_sys_i;
    logic        reset_n_i;
    logic        hsel_i;
    logic        hwrite_i;
    logic        pull_scl;
    logic        pull_sda;
    logic [31:0] haddr_i;
    logic [31:0] hwdata_i;
    logic [1:0]  htrans_i;
    logic [31:0] hrdata_o;
    logic        hreadyout_o;
    logic        hresp;
    logic        scl;
    logic        sda;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic [1:0]  mode_o;
    logic        irq_o;
    logic [8:0]  bits;
    logic [7:0]  count;
    logic [7:0]  starts;
    logic [7:0]  rd;
    int          n;
    int          fails;
    int          check_count;

    i2cmt_ctrl #(.HALF_CYC(4)) i_i2cmt_ctrl (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp),
        .scl_i(scl), .scl_o(), .scl_oe_n_o(scl_oe_n), .sda_i(sda),
        .sda_o(), .sda_oe_n_o(sda_oe_n), .mode_o(mode_o), .irq_o(irq_o));

    i2cmt_bus_model i_i2cmt_bus_model (
        .scl_oe_n_i(scl_oe_n), .sda_oe_n_i(sda_oe_n), .pull_scl_i(pull_scl),
        .pull_sda_i(pull_sda), .scl_o(scl), .sda_o(sda), .bits_o(bits),
        .count_o(count), .starts_o(starts));

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task tick;
        @(posedge clk_sys_i);
        n++;
        if (n > 3000) begin
            fails++;
            report_and_stop;
        end
    endtask

    task edge_rdy;
        tick;
        while (hreadyout_o !== 1'b1) tick;
    endtask

    // Extra edge after a write: an output such as mode_o sampled at once would see the old value
    task bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        hsel_i   <= 1'b1;
        haddr_i  <= {14'h0, idx, 2'b00};
        htrans_i <= 2'b10;
        hwrite_i <= wr;
        edge_rdy;
        htrans_i <= 2'b00;
        hwdata_i <= {24'h0, wd};
        edge_rdy;
        rd = hrdata_o[7:0];
        chk("hresp", 8'h00, {7'h0, hresp});
        if (wr) @(posedge clk_sys_i);
    endtask

    task rchk(input string nm, input logic [15:0] idx,
              input logic [7:0] msk, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(nm, exp, rd & msk);
    endtask

    initial begin
        fails = 0;
        check_count = 0;
        reset_n_i = 1'b0;
        hsel_i = 1'b0;
        haddr_i = 32'h0;
        htrans_i = 2'b00;
        hwrite_i = 1'b0;
        hwdata_i = 32'h0;
        pull_scl = 1'b0;
        pull_sda = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        chk("mode", 8'h00, {6'h0, mode_o});
        rchk("hold", i2cmt_pkg::HOLD_IDX, 8'hff, 8'hff);
        rchk("ctrl2", i2cmt_pkg::CTRL2_IDX, 8'hc0, 8'h40);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, i2cmt_pkg::HOLD_IDX, 8'h5a ^ {8{i[0]}});
            rchk("hold", i2cmt_pkg::HOLD_IDX, 8'hff,
                 8'h5a ^ {8{i[0]}});
        end
        rchk("empty", i2cmt_pkg::STAT_IDX, 8'h80, 8'h00);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, i2cmt_pkg::CTRL1_IDX, {2'b00, m[1:0], 4'h0});
            chk("mode", {6'h0, m[1:0]}, {6'h0, mode_o});
            rchk("ctrl1", i2cmt_pkg::CTRL1_IDX, 8'h30,
                 {2'b00, m[1:0], 4'h0});
        end
        bus(1'b1, i2cmt_pkg::CTRL2_IDX, 8'hc0);
        repeat (20) @(posedge clk_sys_i);
        chk("starts", 8'h00, starts);
        bus(1'b1, i2cmt_pkg::CTRL1_IDX, 8'h00);
        bus(1'b1, i2cmt_pkg::STAT_IDX, 8'hff);
        bus(1'b1, i2cmt_pkg::MASK_IDX, 8'h00);
        pull_sda <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        rchk("busy", i2cmt_pkg::CTRL2_IDX, 8'h80, 8'h80);
        chk("irq", 8'h00, {7'h0, irq_o});
        bus(1'b1, i2cmt_pkg::MASK_IDX, 8'h02);
        @(posedge clk_sys_i);
        chk("irq", 8'h01, {7'h0, irq_o});
        bus(1'b1, i2cmt_pkg::STAT_IDX, 8'h02);
        @(posedge clk_sys_i);
        chk("irq", 8'h00, {7'h0, irq_o});
        pull_sda <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        rchk("busy", i2cmt_pkg::CTRL2_IDX, 8'h80, 8'h00);
        bus(1'b1, i2cmt_pkg::CTRL1_IDX, 8'h30);
        bus(1'b1, i2cmt_pkg::HOLD_IDX, 8'ha5);
        bus(1'b1, i2cmt_pkg::CTRL2_IDX, 8'h80);
        n = 0;
        while (count < 8'd2) tick;
        chk("starts", 8'h02, starts);
        rchk("busy", i2cmt_pkg::CTRL2_IDX, 8'h80, 8'h80);
        // Start also sets buffer empty, so clear it before waiting for a move
        bus(1'b1, i2cmt_pkg::STAT_IDX, 8'h80);
        rd = 8'h00;
        while (rd[7] !== 1'b1) bus(1'b0, i2cmt_pkg::STAT_IDX, 8'h00);
        bus(1'b1, i2cmt_pkg::HOLD_IDX, 8'h3c);
        // First byte was already moved in when mode 11 was first written
        while (count < 8'd9) tick;
        chk("byte0", 8'ha5, bits[8:1]);
        while (count < 8'd18) tick;
        chk("byte1", 8'ha5, bits[8:1]);
        while (count < 8'd27) tick;
        chk("byte2", 8'h3c, bits[8:1]);
        while (scl !== 1'b0) tick;
        bus(1'b1, i2cmt_pkg::CTRL2_IDX, 8'h80);
        while (starts < 8'd3) tick;
        while (scl !== 1'b0) tick;
        bus(1'b1, i2cmt_pkg::CTRL2_IDX, 8'h00);
        while (sda !== 1'b1 || scl !== 1'b1) tick;
        repeat (8) @(posedge clk_sys_i);
        rchk("busy", i2cmt_pkg::CTRL2_IDX, 8'h80, 8'h00);
        bus(1'b1, i2cmt_pkg::HOLD_IDX, 8'hff);
        bus(1'b1, i2cmt_pkg::CTRL2_IDX, 8'h80);
        n = 0;
        while (count < 8'd1 || scl !== 1'b0) tick;
        // Another master holds SDA low so the next one bit is lost
        pull_sda <= 1'b1;
        while (mode_o !== 2'b00) tick;
        rchk("ctrl1", i2cmt_pkg::CTRL1_IDX, 8'h30, 8'h00);
        rchk("lost", i2cmt_pkg::STAT_IDX, 8'h04, 8'h04);
        report_and_stop;
    end
endmodule

`default_nettype wire
